// [chg_pkg.sv]
// Package: register map, field positions, codes and timing for the charger control block
package chg_pkg;
  localparam logic [2:0] CHG_ADDR_STATUS = 3'h0;
  localparam logic [2:0] CHG_ADDR_CONTROL = 3'h1;
  localparam logic [2:0] CHG_ADDR_FLOAT = 3'h2;
  localparam logic [2:0] CHG_ADDR_CURRENT = 3'h4;
  localparam logic [2:0] CHG_ADDR_SAG = 3'h5;
  localparam logic [2:0] CHG_ADDR_SAFETY = 3'h6;

  localparam logic [7:0] CHG_CONTROL_RST = 8'h70;
  localparam logic [7:0] CHG_FLOAT_RST = 8'h0a;
  localparam logic [7:0] CHG_CURRENT_RST = 8'h00;
  localparam logic [7:0] CHG_SAG_RST = 8'h04;
  localparam logic [7:0] CHG_SAFETY_RST = 8'h00;

  localparam int CHG_CUTOFF_BIT = 3;
  localparam int CHG_HZ_BIT = 1;
  localparam int CHG_BOOST_BIT = 0;
  // Hold bit sits below the current code in the same register, so one write sets both
  localparam int CHG_HOLD_BIT = 3;
  localparam int CHG_POL_BIT = 3;
  localparam int CHG_PERMIT_BIT = 4;
  localparam int CHG_SAG_BIT = 2;

  localparam logic [5:0] CHG_VCODE_A_MAX = 6'h23;
  localparam logic [5:0] CHG_VCODE_B_MAX = 6'h2c;
  localparam logic [5:0] CHG_VCEIL_0 = 6'h23;
  localparam logic [5:0] CHG_VCEIL_1 = 6'h2c;
  localparam logic [5:0] CHG_VCEIL_2 = 6'h32;
  localparam logic [3:0] CHG_VSAFE_MID_MAX = 4'h9;

  localparam logic [1:0] CHG_STAT_READY = 2'h0;
  localparam logic [1:0] CHG_STAT_RUN = 2'h1;
  localparam logic [1:0] CHG_STAT_DONE = 2'h2;
  localparam logic [1:0] CHG_STAT_FAULT = 2'h3;

  localparam logic [2:0] CHG_FLT_NONE = 3'h0;
  localparam logic [2:0] CHG_FLT_BUS_OV = 3'h1;
  localparam logic [2:0] CHG_FLT_POOR = 3'h3;
  localparam logic [2:0] CHG_FLT_BAT_OV = 3'h4;
  localparam logic [2:0] CHG_FLT_THERMAL = 3'h5;

  localparam int CHG_CLK_HZ = 100_000_000;
  localparam int CHG_QUALIFY_MS = 30;
  localparam int CHG_WAKE_MIN = 90;
  localparam int CHG_NORMAL_H = 12;
  localparam longint CHG_QUALIFY_CYC = longint'(CHG_CLK_HZ) / 1000 * CHG_QUALIFY_MS;
  localparam longint CHG_WAKE_CYC = longint'(CHG_CLK_HZ) * 60 * CHG_WAKE_MIN;
  localparam longint CHG_NORMAL_CYC = longint'(CHG_CLK_HZ) * 3600 * CHG_NORMAL_H;

  typedef enum logic [1:0] {
    CHG_MODE_CHARGE = 2'b00,
    CHG_MODE_OFF = 2'b01,
    CHG_MODE_BOOST = 2'b10,
    CHG_MODE_HIZ = 2'b11
  } chg_mode_t;

  typedef struct packed {
    logic bus_valid;
    logic bus_over;
    logic bus_poor;
    logic bat_over;
    logic die_hot;
    logic die_cool;
    logic low_current;
    logic recharge_low;
    logic resume_low;
    logic boost_fault;
  } chg_sense_t;

  typedef struct packed {
    logic [5:0] float_code;
    logic [2:0] current_code;
    logic [1:0] input_cap;
    logic sag_level_select;
  } chg_setting_t;
endpackage

// [chg_timer.sv]
// Clearable cycle counter with pause, used for qualification and safety timeouts
`timescale 1ns/10ps
`default_nettype none
module chg_timer #(
  parameter int W = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic expired
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic at_end;

  assign at_end = (cnt_q >= limit);
  assign cnt_d = clear ? '0 : ((run && !at_end) ? cnt_q + W'(1) : cnt_q);
  assign expired = at_end && !clear;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule // chg_timer
`default_nettype wire

// [chg_ctrl.sv]
// Charger mode control, validation, timers, clamping and status registers
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Six-bit float code maps to three voltages
// - Low current with cutoff enabled ends charging
// - Battery below float minus margin restarts charge
// - Three-bit current code selects sense voltage
// - Wake timer expiry with hold bit stops until input is removed
// - Twelve-hour expiry stops until battery drops
// - Input qualified thirty milliseconds before each start
// - Two-bit field selects input current cap
// - Ramp current, hold input at sag threshold
// - Sag select bit picks threshold level
// - Writes above safety ceiling store the ceiling
// - Voltage ceiling field maps to three caps
// - Over-temperature suspends, freezes timers, fault 101
// - Input over-voltage suspends, revalidate after clearing
// - Power-on defaults keep charging at 4.2 V
// - Fault field codes for charge mode
// - Charging status read in status bits 5:4
// - Disable pin, hiz and boost bits pick mode
// - Boost request bit self-clears when boost stops
// - Hiz bit write stops boost only
// - Boost pin acts through polarity, overrides hiz
// - Status codes ready, running, done, fault
module chg_ctrl
  import chg_pkg::*;
#(
  parameter longint QUALIFY_CYC = CHG_QUALIFY_CYC,
  parameter longint WAKE_CYC = CHG_WAKE_CYC,
  parameter longint NORMAL_CYC = CHG_NORMAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic disable_pin,
  input wire logic boost_pin,
  input wire chg_sense_t sense,
  output logic charge_enable,
  output logic boost_enable,
  output logic ramp_enable,
  output logic hold_at_sag,
  output logic [1:0] mode,
  output chg_setting_t setting
);
  // Wide enough for the twelve-hour count at the full clock rate
  localparam int TW = 48;

  typedef enum logic [2:0] {
    CHG_ST_IDLE = 3'b000,
    CHG_ST_QUALIFY = 3'b001,
    CHG_ST_CHARGE = 3'b010,
    CHG_ST_DONE = 3'b011,
    CHG_ST_TIMEOUT = 3'b100,
    CHG_ST_LOCKED = 3'b101
  } chg_state_t;

  chg_state_t st_q;
  chg_state_t st_d;
  logic [7:0] control_q;
  logic [7:0] float_q;
  logic [7:0] current_q;
  logic [7:0] sag_q;
  logic [7:0] safety_q;
  logic [7:0] reg_rdata_q;
  logic [2:0] fault_q;
  logic wake_q;
  logic hot_q;
  logic [1:0] dis_sync_q;
  logic [1:0] pin_sync_q;
  chg_sense_t sense_s1_q;
  chg_sense_t sense_q;

  // Pins and analog comparators are asynchronous: two stages before use
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dis_sync_q <= 2'b00;
      pin_sync_q <= 2'b00;
      sense_s1_q <= '0;
      sense_q <= '0;
    end
    else
    begin
      dis_sync_q <= {dis_sync_q[0], disable_pin};
      pin_sync_q <= {pin_sync_q[0], boost_pin};
      sense_s1_q <= sense;
      sense_q <= sense_s1_q;
    end
  end

  wire dis = dis_sync_q[1];
  wire pin_active = pin_sync_q[1] == control_q[CHG_POL_BIT];
  wire permit = sag_q[CHG_PERMIT_BIT];
  wire hiz_bit = control_q[CHG_HZ_BIT];
  wire boost_bit = control_q[CHG_BOOST_BIT];
  wire pin_req = permit && pin_active;
  wire boost_req = pin_req || (boost_bit && !hiz_bit);

  // Disable pin wins, pin boost beats hiz, hiz keeps charging alive
  wire chg_mode_t mode_w = dis ? CHG_MODE_OFF :
    (boost_req ? CHG_MODE_BOOST : (hiz_bit ? CHG_MODE_HIZ : CHG_MODE_CHARGE));
  wire charge_mode = (mode_w == CHG_MODE_CHARGE) || (mode_w == CHG_MODE_HIZ);
  wire boost_stop = boost_bit && ((mode_w != CHG_MODE_BOOST) || sense_q.boost_fault);

  // Safety ceilings
  wire [3:0] vsafe = safety_q[3:0];
  wire [2:0] isafe = safety_q[6:4];
  wire [5:0] vceil = (vsafe == 4'h0) ? CHG_VCEIL_0 :
    ((vsafe <= CHG_VSAFE_MID_MAX) ? CHG_VCEIL_1 : CHG_VCEIL_2);
  wire [5:0] vin = reg_wdata[7:2];
  wire [5:0] vstore = (vin > vceil) ? vceil : vin;
  wire [2:0] iin = reg_wdata[6:4];
  wire [2:0] istore = (iin > isafe) ? isafe : iin;

  wire wr_ctl = reg_wr && (reg_addr == CHG_ADDR_CONTROL);
  wire wr_flt = reg_wr && (reg_addr == CHG_ADDR_FLOAT);
  wire wr_cur = reg_wr && (reg_addr == CHG_ADDR_CURRENT);
  wire wr_sag = reg_wr && (reg_addr == CHG_ADDR_SAG);
  wire wr_saf = reg_wr && (reg_addr == CHG_ADDR_SAFETY);

  // Hardware clear of boost request outranks a host write of the same cycle
  wire [7:0] ctl_wr_val = wr_ctl ? reg_wdata : control_q;
  wire [7:0] control_d = boost_stop ? (ctl_wr_val & ~(8'h01 << CHG_BOOST_BIT)) :
    ctl_wr_val;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      control_q <= CHG_CONTROL_RST;
      float_q <= CHG_FLOAT_RST;
      current_q <= CHG_CURRENT_RST;
      sag_q <= CHG_SAG_RST;
      safety_q <= CHG_SAFETY_RST;
    end
    else
    begin
      control_q <= control_d;
      if (wr_flt)
        float_q <= {vstore, reg_wdata[1:0]};
      if (wr_cur)
        current_q <= {reg_wdata[7], istore, reg_wdata[3:0]};
      if (wr_sag)
        sag_q <= reg_wdata;
      if (wr_saf)
        safety_q <= reg_wdata;
    end
  end

  // Suspend cause: over-temperature freezes the sequence rather than resetting it
  wire hot = sense_q.die_hot || hot_q;
  wire suspend = hot;
  wire bus_ok = sense_q.bus_valid && !sense_q.bus_over;

  logic q_clear;
  logic q_exp;
  logic w_clear;
  logic w_exp;
  logic n_clear;
  logic n_exp;

  assign q_clear = (st_q != CHG_ST_QUALIFY) || !bus_ok;
  chg_timer #(.W(TW)) u_qualify (
    .clk(clk),
    .rst(rst),
    .clear(q_clear),
    .run(!suspend),
    .limit(TW'(QUALIFY_CYC)),
    .expired(q_exp)
  );

  assign w_clear = !sense_q.bus_valid || (st_q == CHG_ST_IDLE);
  chg_timer #(.W(TW)) u_wake (
    .clk(clk),
    .rst(rst),
    .clear(w_clear),
    .run(st_q == CHG_ST_CHARGE && wake_q && !suspend),
    .limit(TW'(WAKE_CYC)),
    .expired(w_exp)
  );

  assign n_clear = !sense_q.bus_valid || (st_q == CHG_ST_IDLE) || (st_q == CHG_ST_DONE);
  chg_timer #(.W(TW)) u_normal (
    .clk(clk),
    .rst(rst),
    .clear(n_clear),
    .run(st_q == CHG_ST_CHARGE && !wake_q && !suspend),
    .limit(TW'(NORMAL_CYC)),
    .expired(n_exp)
  );

  wire hold_bit = current_q[CHG_HOLD_BIT];
  wire cutoff = control_q[CHG_CUTOFF_BIT];

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      CHG_ST_IDLE:
        if (charge_mode && bus_ok)
          st_d = CHG_ST_QUALIFY;
      CHG_ST_QUALIFY:
        if (!charge_mode || !sense_q.bus_valid)
          st_d = CHG_ST_IDLE;
        else if (q_exp)
          st_d = CHG_ST_CHARGE;
      CHG_ST_CHARGE:
        if (!charge_mode || !sense_q.bus_valid)
          st_d = CHG_ST_IDLE;
        else if (sense_q.bus_over)
          st_d = CHG_ST_QUALIFY;
        else if (suspend)
          st_d = CHG_ST_CHARGE;
        else if (w_exp && hold_bit)
          st_d = CHG_ST_LOCKED;
        else if (n_exp)
          st_d = CHG_ST_TIMEOUT;
        else if (cutoff && sense_q.low_current)
          st_d = CHG_ST_DONE;
      CHG_ST_DONE:
        if (!charge_mode || !sense_q.bus_valid)
          st_d = CHG_ST_IDLE;
        else if (sense_q.recharge_low)
          st_d = CHG_ST_QUALIFY;
      CHG_ST_TIMEOUT:
        if (!sense_q.bus_valid)
          st_d = CHG_ST_IDLE;
        else if (sense_q.resume_low)
          st_d = CHG_ST_QUALIFY;
      CHG_ST_LOCKED:
        if (!sense_q.bus_valid)
          st_d = CHG_ST_IDLE;
      default:
        st_d = CHG_ST_IDLE;
    endcase
  end

  // Fault code: thermal outranks input faults; over-voltage clears on comparator release
  wire [2:0] fault_d = hot ? CHG_FLT_THERMAL :
    (sense_q.bus_over ? CHG_FLT_BUS_OV :
    (sense_q.bus_poor ? CHG_FLT_POOR :
    (sense_q.bat_over ? CHG_FLT_BAT_OV : CHG_FLT_NONE)));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= CHG_ST_IDLE;
      fault_q <= CHG_FLT_NONE;
      wake_q <= 1'b1;
      hot_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      fault_q <= fault_d;
      // Stay suspended until the cool comparator trips, not merely when hot drops
      if (sense_q.die_hot)
        hot_q <= 1'b1;
      else if (sense_q.die_cool)
        hot_q <= 1'b0;
      // Wake phase lasts until the host drops the low-current hold bit
      if (st_q == CHG_ST_IDLE)
        wake_q <= 1'b1;
      else if (!hold_bit)
        wake_q <= 1'b0;
    end
  end

  wire [1:0] stat_w = (fault_q != CHG_FLT_NONE) || (st_q == CHG_ST_LOCKED) ? CHG_STAT_FAULT :
    ((st_q == CHG_ST_DONE) ? CHG_STAT_DONE :
    ((st_q == CHG_ST_QUALIFY) || (st_q == CHG_ST_CHARGE) ? CHG_STAT_RUN :
    CHG_STAT_READY));
  wire in_boost = mode_w == CHG_MODE_BOOST;
  wire [7:0] status_w = {2'b00, stat_w, in_boost, fault_q};

  wire [7:0] rd_mux = (reg_addr == CHG_ADDR_STATUS) ? status_w :
    (reg_addr == CHG_ADDR_CONTROL) ? control_q :
    (reg_addr == CHG_ADDR_FLOAT) ? float_q :
    (reg_addr == CHG_ADDR_CURRENT) ? current_q :
    (reg_addr == CHG_ADDR_SAG) ? sag_q :
    (reg_addr == CHG_ADDR_SAFETY) ? safety_q : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_mux;
  end

  assign reg_rdata = reg_rdata_q;
  assign mode = mode_w;
  assign charge_enable = (st_q == CHG_ST_CHARGE) && !suspend && !sense_q.bus_over;
  assign boost_enable = in_boost && !sense_q.boost_fault;
  // Current ramps while charging; input voltage loop holds at the sag level
  assign ramp_enable = charge_enable;
  assign hold_at_sag = charge_enable && sense_q.bus_poor;
  // Analog decodes these codes: float code bins, sense mV step, cap table
  // One driver for the whole struct; fields in declaration order
  assign setting = {
    float_q[7:2],
    current_q[6:4],
    control_q[7:6],
    sag_q[CHG_SAG_BIT]
  };
endmodule // chg_ctrl
`default_nettype wire

// [chg_ctrl_monitor.sv]
// Port-level property checker for the charger control block
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl_monitor
  import chg_pkg::*;
#(
  parameter longint QUALIFY_CYC = CHG_QUALIFY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic disable_pin,
  input wire chg_sense_t sense,
  input wire logic charge_enable,
  input wire logic boost_enable,
  input wire logic [1:0] mode,
  input wire chg_setting_t setting
);
  logic [7:0] safe_q;
  logic [31:0] ok_q;
  wire [5:0] vcap = safe_q[3:0] == 4'h0 ? CHG_VCEIL_0 :
    (safe_q[3:0] <= CHG_VSAFE_MID_MAX ? CHG_VCEIL_1 : CHG_VCEIL_2);
  wire [5:0] vreq = reg_wdata[7:2] > vcap ? vcap : reg_wdata[7:2];
  wire [2:0] ireq = reg_wdata[6:4] > safe_q[6:4] ? safe_q[6:4] : reg_wdata[6:4];
  // Shadow of the ceiling register so clamped writes can be predicted
  always_ff @(posedge clk)
  begin
    if (rst)
      safe_q <= CHG_SAFETY_RST;
    else if (reg_wr && reg_addr == CHG_ADDR_SAFETY)
      safe_q <= reg_wdata;
  end
  // Raw input is counted, so the synchroniser delay only adds slack
  always_ff @(posedge clk)
  begin
    if (rst || !sense.bus_valid || sense.bus_over)
      ok_q <= 32'h0;
    else if (ok_q != 32'hffffffff)
      ok_q <= ok_q + 32'h1;
  end
  a_float_clamp: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == CHG_ADDR_FLOAT |=> setting.float_code == $past(vreq))
    else $error("float code not clamped to ceiling");
  a_current_clamp: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == CHG_ADDR_CURRENT |=> setting.current_code == $past(ireq))
    else $error("current code not clamped to ceiling");
  a_cap_field: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == CHG_ADDR_CONTROL |=> setting.input_cap == $past(reg_wdata[7:6]))
    else $error("input cap field wrong");
  a_sag_field: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == CHG_ADDR_SAG |=> setting.sag_level_select == $past(reg_wdata[2]))
    else $error("sag select wrong");
  a_disable_off: assert property (@(posedge clk) disable iff (rst)
    disable_pin[*4] |-> mode == CHG_MODE_OFF && !charge_enable && !boost_enable)
    else $error("disable pin did not turn charger off");
  a_qualify_span: assert property (@(posedge clk) disable iff (rst)
    $rose(charge_enable) |-> ok_q >= QUALIFY_CYC)
    else $error("charging started before input qualified");
  a_over_stops: assert property (@(posedge clk) disable iff (rst)
    sense.bus_over[*4] |-> !charge_enable)
    else $error("charging during input over-voltage");
  a_hot_fault: assert property (@(posedge clk) disable iff (rst)
    (sense.die_hot && sense.bus_valid && !sense.bus_over && !disable_pin)[*4] ##0
    reg_rd && reg_addr == CHG_ADDR_STATUS |=> reg_rdata[2:0] == CHG_FLT_THERMAL)
    else $error("thermal fault code wrong");
  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_boost_mode: assert property (@(posedge clk) disable iff (rst)
    boost_enable |-> mode == CHG_MODE_BOOST)
    else $error("boost enabled outside boost mode");
  a_boost_on: assert property (@(posedge clk) disable iff (rst)
    (mode == CHG_MODE_BOOST && !sense.boost_fault)[*3] |-> boost_enable)
    else $error("boost mode without boost enable");
  a_boost_selfclear: assert property (@(posedge clk) disable iff (rst)
    mode != CHG_MODE_BOOST && !reg_wr ##1 reg_rd && reg_addr == CHG_ADDR_CONTROL
    |=> !reg_rdata[0])
    else $error("boost request bit not cleared outside boost");
endmodule // chg_ctrl_monitor
bind chg_ctrl chg_ctrl_monitor #(.QUALIFY_CYC(QUALIFY_CYC)) u_mon (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .disable_pin(disable_pin), .sense(sense),
  .charge_enable(charge_enable), .boost_enable(boost_enable), .mode(mode), .setting(setting));
`default_nettype wire

// [chg_power_model.sv]
// Power-side model: input source, battery and die sensing levels
`timescale 1ns/10ps
`default_nettype none
module chg_power_model
  import chg_pkg::*;
(
  input wire logic plug,
  input wire logic over,
  input wire logic hot,
  input wire logic full,
  input wire logic drop,
  input wire logic bfault,
  input wire logic poor,
  input wire logic batov,
  output chg_sense_t sense
);
  // Over-voltage is only seen while a source is present
  assign sense = '{plug, plug && over, plug && poor, plug && batov, hot, !hot, plug && full,
    drop, drop, bfault};
endmodule // chg_power_model
`default_nettype wire

// [testbench.sv]
// Register-level test sequence for the charger control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import chg_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, disable_pin = 0, boost_pin = 0;
  logic plug = 0, over = 0, hot = 0, full = 0, drop = 0, bfault = 0, poor = 0, batov = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic charge_enable, boost_enable, ramp_enable, hold_at_sag;
  logic [1:0] mode;
  chg_sense_t sense;
  chg_setting_t setting;
  logic [3:0] vs [3] = '{4'h0, 4'h9, 4'ha};
  logic [5:0] vc [3] = '{6'h23, 6'h2c, 6'h32};
  int fails = 0, num_checks = 0, k;
  chg_power_model u_pwr (.plug(plug), .over(over), .hot(hot), .full(full), .drop(drop),
    .bfault(bfault), .poor(poor), .batov(batov), .sense(sense));
  chg_ctrl #(.QUALIFY_CYC(20), .WAKE_CYC(200), .NORMAL_CYC(50000)) u_dut (.clk(clk),
    .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .disable_pin(disable_pin), .boost_pin(boost_pin), .sense(sense),
    .charge_enable(charge_enable), .boost_enable(boost_enable), .ramp_enable(ramp_enable),
    .hold_at_sag(hold_at_sag), .mode(mode), .setting(setting));
  always #5 clk = ~clk;
  task automatic test_done;
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata & m, e);
  endtask
  // Bounded wait; also checks charging is still off on the 13th cycle (i == 12) when asked
  task automatic wait_chg(input logic e, input logic early);
    int i;
    for (i = 0; i < 60; i++)
    begin
      @(posedge clk);
      #1;
      if (early && i == 12)
        check(8'(charge_enable), 8'h00);
      if (charge_enable === e && !(early && i < 12))
        break;
    end
    check(8'(charge_enable), 8'(e));
  endtask
  initial
  begin
    #200000;
    fails++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(CHG_ADDR_CONTROL, 8'hff, CHG_CONTROL_RST);
    rdc(CHG_ADDR_FLOAT, 8'hff, CHG_FLOAT_RST);
    rdc(CHG_ADDR_CURRENT, 8'hff, CHG_CURRENT_RST);
    rdc(CHG_ADDR_SAG, 8'hff, CHG_SAG_RST);
    rdc(CHG_ADDR_SAFETY, 8'hff, CHG_SAFETY_RST);
    rdc(CHG_ADDR_STATUS, 8'h30, {2'h0, CHG_STAT_READY, 4'h0});
    wr(3'h3, 8'h5a);
    rdc(3'h3, 8'hff, 8'h00);
    plug <= 1'b1;
    wait_chg(1'b1, 1'b1);
    rdc(CHG_ADDR_STATUS, 8'h37, {2'h0, CHG_STAT_RUN, 4'h0});
    poor <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check(8'({ramp_enable, hold_at_sag}), 8'h03);
    rdc(CHG_ADDR_STATUS, 8'h37, {2'h0, CHG_STAT_FAULT, 1'b0, CHG_FLT_POOR});
    poor <= 1'b0;
    batov <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(CHG_ADDR_STATUS, 8'h07, {5'h0, CHG_FLT_BAT_OV});
    batov <= 1'b0;
    for (k = 0; k < 3; k++)
    begin
      wr(CHG_ADDR_SAFETY, {4'h4, vs[k]});
      wr(CHG_ADDR_CONTROL, 8'hc8);
      wr(CHG_ADDR_FLOAT, 8'hf8);
      rdc(CHG_ADDR_FLOAT, 8'hfc, {vc[k], 2'b00});
    end
    for (k = 0; k < 8; k++)
    begin
      wr(CHG_ADDR_CURRENT, {1'b0, 3'(k), 4'h0});
      check(8'(setting.current_code), 8'(k > 4 ? 4 : k));
    end
    wr(CHG_ADDR_CURRENT, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      wr(CHG_ADDR_CONTROL, {2'(k), 6'h08});
      check(8'(setting.input_cap), 8'(k));
    end
    for (k = 0; k < 2; k++)
    begin
      wr(CHG_ADDR_SAG, {5'h02, 1'(k), 2'h0});
      check(8'(setting.sag_level_select), 8'(k));
    end
    full <= 1'b1;
    wait_chg(1'b0, 1'b0);
    rdc(CHG_ADDR_STATUS, 8'h30, {2'h0, CHG_STAT_DONE, 4'h0});
    full <= 1'b0;
    drop <= 1'b1;
    wait_chg(1'b1, 1'b1);
    drop <= 1'b0;
    hot <= 1'b1;
    wait_chg(1'b0, 1'b0);
    rdc(CHG_ADDR_STATUS, 8'h07, {5'h0, CHG_FLT_THERMAL});
    hot <= 1'b0;
    wait_chg(1'b1, 1'b0);
    over <= 1'b1;
    wait_chg(1'b0, 1'b0);
    rdc(CHG_ADDR_STATUS, 8'h37, {2'h0, CHG_STAT_FAULT, 1'b0, CHG_FLT_BUS_OV});
    over <= 1'b0;
    wait_chg(1'b1, 1'b1);
    wr(CHG_ADDR_CONTROL, 8'hc9);
    check(8'(mode), 8'(CHG_MODE_BOOST));
    check(8'(boost_enable), 8'h01);
    wr(CHG_ADDR_CONTROL, 8'hcb);
    rdc(CHG_ADDR_CONTROL, 8'h03, 8'h02);
    check(8'(mode), 8'(CHG_MODE_HIZ));
    wait_chg(1'b1, 1'b0);
    boost_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check(8'(mode), 8'(CHG_MODE_BOOST));
    boost_pin <= 1'b0;
    wr(CHG_ADDR_CONTROL, 8'hc9);
    bfault <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(CHG_ADDR_CONTROL, 8'h01, 8'h00);
    bfault <= 1'b0;
    disable_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check(8'(mode), 8'(CHG_MODE_OFF));
    disable_pin <= 1'b0;
    wr(CHG_ADDR_CURRENT, 8'h08);
    repeat (300) @(posedge clk);
    #1 check(8'(charge_enable), 8'h00);
    rdc(CHG_ADDR_STATUS, 8'h30, {2'h0, CHG_STAT_FAULT, 4'h0});
    test_done();
  end
endmodule // testbench
`default_nettype wire
